/* rtl/ppp_consts.vh */
// Constants for the PROM programming port controller.
// Assumes a 10 MHz core clock; included by the controller only.
`ifndef PPP_CONSTS_VH
`define PPP_CONSTS_VH
`define PPP_CLK_HZ         24'h989680
`define PPP_PULSE_NS       17'h186A0
// 0.1 ms write pulse in 100 ns clock cycles
`define PPP_PULSE_CYC      16'h03E8
`define PPP_SETUP_CYC      16'h0004
`define PPP_MAX_TRIES      4'hA
`define PPP_PAGE_BYTES     3'h4
`define PPP_ADDR_W         15
`define PPP_LAST_ADDR      15'h5FFF
`define PPP_ERASED         8'hFF
`define PPP_CMD_READ       3'h0
`define PPP_CMD_BYTE       3'h1
`define PPP_CMD_PAGE       3'h2
`define PPP_CMD_CHECK      3'h3
`endif

/* rtl/ppp_ctrl.v */
// Host-side controller driving the PROM programming pins of the part.
// Assumes supplies are switched by outside circuits from o_* requests.
`timescale 1ns/100ps
`include "ppp_consts.vh"

module ppp_ctrl (
  input  wire        i_core_clk,
  input  wire        i_reset,
  input  wire        i_start,
  input  wire [2:0]  i_cmd,
  input  wire [14:0] i_addr,
  input  wire [7:0]  i_wdata,
  input  wire [31:0] i_page_data,
  input  wire [7:0]  i_dq_in,
  output wire        o_ready,
  output reg         o_done_ff,
  output reg         o_fail_ff,
  output reg  [7:0]  o_rdata_ff,
  output reg  [14:0] o_prom_addr_ff,
  output reg  [7:0]  o_dq_out_ff,
  output reg         o_dq_oe_n_ff,
  output reg         o_prom_select_n_ff,
  output reg         o_read_strobe_n_ff,
  output reg         o_write_pulse_n_ff,
  output reg         o_dev_reset_n_ff,
  output reg         o_high_volt_ff
);

  localparam ST_IDLE  = 4'h0;
  localparam ST_SETUP = 4'h1;
  localparam ST_LATCH = 4'h2;
  localparam ST_PULSE = 4'h3;
  localparam ST_VERI  = 4'h4;
  localparam ST_VSAMP = 4'h5;
  localparam ST_READ  = 4'h6;
  localparam ST_RSAMP = 4'h7;
  localparam ST_END   = 4'h8;

  localparam [15:0] PULSE_CYC = `PPP_PULSE_CYC;
  localparam [15:0] SETUP_CYC = `PPP_SETUP_CYC;

  reg [7:0]  dq_s1_ff;
  reg [7:0]  dq_s2_ff;
  reg [3:0]  state_ff;
  reg [2:0]  cmd_ff;
  reg [15:0] cnt_ff;
  reg [1:0]  idx_ff;
  reg [3:0]  tries_ff;
  reg        bad_ff;
  reg [14:0] base_ff;
  reg [31:0] page_ff;

  // Byte of the latched page picked by index
  function [7:0] page_byte;
    input [31:0] pg;
    input [1:0]  ix;
    begin
      page_byte = pg[ix*8 +: 8];
    end
  endfunction

  // Write commands raise the supplies and are range checked
  function is_wr_cmd;
    input [2:0] c;
    begin
      is_wr_cmd = (c == `PPP_CMD_PAGE) || (c == `PPP_CMD_BYTE);
    end
  endfunction

  // Next address of a page walk; stays inside 15 bits
  function [14:0] addr_step;
    input [14:0] a;
    begin
      addr_step = a + 15'h0001;
    end
  endfunction

  // Data pins come from the part: two flops before any use
  always @(posedge i_core_clk) begin
    dq_s1_ff <= i_dq_in;
    dq_s2_ff <= dq_s1_ff;
  end

  assign o_ready = (state_ff == ST_IDLE);

  wire [7:0] exp_byte = (cmd_ff == `PPP_CMD_PAGE) ? page_byte(page_ff, idx_ff)
                      : (cmd_ff == `PPP_CMD_CHECK) ? `PPP_ERASED : page_ff[7:0];
  wire       last_ix  = (cmd_ff != `PPP_CMD_PAGE) ||
                        (idx_ff == `PPP_PAGE_BYTES - 3'h1);
  // Retry and verify restart at the page base for page writes, else at the byte's own address
  wire [14:0] rewind_addr = (cmd_ff == `PPP_CMD_PAGE) ? base_ff
                                                      : o_prom_addr_ff;

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      // Device reset pin held low from reset on: part stays in prog mode
      state_ff           <= ST_IDLE;
      cmd_ff             <= 3'h0;
      cnt_ff             <= 16'h0000;
      idx_ff             <= 2'h0;
      tries_ff           <= 4'h0;
      bad_ff             <= 1'b0;
      base_ff            <= 15'h0000;
      page_ff            <= 32'h00000000;
      o_done_ff          <= 1'b0;
      o_fail_ff          <= 1'b0;
      o_rdata_ff         <= 8'h00;
      o_prom_addr_ff     <= 15'h0000;
      o_dq_out_ff        <= 8'h00;
      o_dq_oe_n_ff       <= 1'b1;
      o_prom_select_n_ff <= 1'b1;
      o_read_strobe_n_ff <= 1'b1;
      o_write_pulse_n_ff <= 1'b1;
      o_dev_reset_n_ff   <= 1'b0;
      o_high_volt_ff     <= 1'b0;
    end else begin
      o_done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          o_dq_oe_n_ff       <= 1'b1;
          o_prom_select_n_ff <= 1'b1;
          o_read_strobe_n_ff <= 1'b1;
          o_write_pulse_n_ff <= 1'b1;
          o_dev_reset_n_ff   <= 1'b0;
          if (i_start) begin
            cmd_ff   <= i_cmd;
            base_ff  <= {i_addr[14:2], 2'h0};
            page_ff  <= (i_cmd == `PPP_CMD_PAGE) ? i_page_data
                                                 : {24'h000000, i_wdata};
            idx_ff   <= 2'h0;
            tries_ff <= 4'h0;
            bad_ff   <= 1'b0;
            o_fail_ff <= 1'b0;
            cnt_ff   <= 16'h0000;
            o_prom_addr_ff <= (i_cmd == `PPP_CMD_PAGE)
                              ? {i_addr[14:2], 2'h0} : i_addr;
            // Out of range writes refused outright
            if (is_wr_cmd(i_cmd) &&
                i_addr > `PPP_LAST_ADDR) begin
              o_fail_ff <= 1'b1;
              o_done_ff <= 1'b1;
            end else begin
              o_high_volt_ff <= is_wr_cmd(i_cmd);
              state_ff <= ST_SETUP;
            end
          end
        end

        ST_SETUP: begin
          // Let supplies settle before touching strobes
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == SETUP_CYC) begin
            cnt_ff <= 16'h0000;
            if (cmd_ff == `PPP_CMD_PAGE) begin
              o_dq_out_ff        <= page_byte(page_ff, 2'h0);
              o_dq_oe_n_ff       <= 1'b0;
              o_read_strobe_n_ff <= 1'b0;
              state_ff <= ST_LATCH;
            end else if (cmd_ff == `PPP_CMD_BYTE) begin
              o_dq_out_ff        <= page_ff[7:0];
              o_dq_oe_n_ff       <= 1'b0;
              o_prom_select_n_ff <= 1'b0;
              o_write_pulse_n_ff <= 1'b0;
              state_ff <= ST_PULSE;
            end else begin
              state_ff <= ST_READ;
            end
          end
        end

        ST_LATCH: begin
          // One cycle per byte, incrementing address
          // Part latches on strobe low; no pulse until all four are in
          if (idx_ff == `PPP_PAGE_BYTES - 3'h1) begin
            o_dq_oe_n_ff       <= 1'b1;
            o_read_strobe_n_ff <= 1'b1;
            o_write_pulse_n_ff <= 1'b0;
            idx_ff   <= 2'h0;
            state_ff <= ST_PULSE;
          end else begin
            idx_ff         <= idx_ff + 2'h1;
            o_prom_addr_ff <= addr_step(o_prom_addr_ff);
            o_dq_out_ff    <= page_byte(page_ff, idx_ff + 2'h1);
          end
        end

        ST_PULSE: begin
          // Pins frozen while the pulse runs; only the counter moves
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == PULSE_CYC - 16'h0001) begin
            cnt_ff             <= 16'h0000;
            o_write_pulse_n_ff <= 1'b1;
            o_dq_oe_n_ff       <= 1'b1;
            o_prom_select_n_ff <= 1'b1;
            tries_ff <= tries_ff + 4'h1;
            bad_ff   <= 1'b0;
            o_prom_addr_ff <= rewind_addr;
            state_ff <= ST_VERI;
          end
        end

        ST_VERI: begin
          // Host stops driving before the part turns on its outputs
          o_dq_oe_n_ff       <= 1'b1;
          o_prom_select_n_ff <= 1'b0;
          o_read_strobe_n_ff <= 1'b0;
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == SETUP_CYC) begin
            cnt_ff   <= 16'h0000;
            state_ff <= ST_VSAMP;
          end
        end

        ST_VSAMP: begin
          // Any wrong byte reruns the whole page, not just that byte
          o_rdata_ff <= dq_s2_ff;
          if (last_ix) begin
            o_prom_select_n_ff <= 1'b1;
            o_read_strobe_n_ff <= 1'b1;
            idx_ff <= 2'h0;
            if (bad_ff || dq_s2_ff != exp_byte) begin
              if (tries_ff == `PPP_MAX_TRIES) begin
                o_fail_ff <= 1'b1;
                state_ff  <= ST_END;
              end else begin
                o_prom_addr_ff <= rewind_addr;
                state_ff <= ST_SETUP;
              end
            end else begin
              state_ff <= ST_END;
            end
          end else begin
            bad_ff <= bad_ff | (dq_s2_ff != exp_byte);
            idx_ff <= idx_ff + 2'h1;
            o_prom_addr_ff <= addr_step(o_prom_addr_ff);
            state_ff <= ST_VERI;
          end
        end

        ST_READ: begin
          o_dq_oe_n_ff       <= 1'b1;
          o_prom_select_n_ff <= 1'b0;
          o_read_strobe_n_ff <= 1'b0;
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == SETUP_CYC) begin
            cnt_ff   <= 16'h0000;
            state_ff <= ST_RSAMP;
          end
        end

        ST_RSAMP: begin
          o_rdata_ff         <= dq_s2_ff;
          o_read_strobe_n_ff <= 1'b1;
          o_prom_select_n_ff <= 1'b1;
          o_fail_ff <= (cmd_ff == `PPP_CMD_CHECK) &&
                       (dq_s2_ff != `PPP_ERASED);
          state_ff <= ST_END;
        end

        ST_END: begin
          // Drop back to 5 V after any write; final sweep is host software
          o_high_volt_ff <= 1'b0;
          o_prom_select_n_ff <= 1'b1;
          o_read_strobe_n_ff <= 1'b1;
          o_write_pulse_n_ff <= 1'b1;
          o_done_ff      <= 1'b1;
          state_ff       <= ST_IDLE;
        end

        default: begin
          // Lost state: release bus and strobes so nothing can be written; high voltage left as it was
          o_dq_oe_n_ff <= 1'b1;
          o_prom_select_n_ff <= 1'b1;
          o_read_strobe_n_ff <= 1'b1;
          o_write_pulse_n_ff <= 1'b1;
          state_ff     <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // ppp_ctrl

/* test/ppp_ctrl_assertions.sv */
// Pin sequencing checks on the PROM programming controller.
// Bound to the controller top; one clock domain.
`timescale 1ns/100ps
module ppp_ctrl_assertions (
  input wire        i_core_clk, i_reset, i_start, o_ready, o_done_ff,
  input wire        o_fail_ff, o_dq_oe_n_ff, o_prom_select_n_ff,
  input wire        o_read_strobe_n_ff, o_write_pulse_n_ff,
  input wire        o_dev_reset_n_ff, o_high_volt_ff,
  input wire [2:0]  i_cmd,
  input wire [14:0] i_addr
);
  reg  [10:0] low_ff;
  wire        wp = o_write_pulse_n_ff, rs = o_read_strobe_n_ff;
  wire        sel = o_prom_select_n_ff, hv = o_high_volt_ff;
  always @(posedge i_core_clk)
    low_ff <= (i_reset || wp) ? 11'h000 : low_ff + 11'h001;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_taken; o_ready && i_start; endsequence
  sequence s_bad; (i_cmd == 3'h1 || i_cmd == 3'h2) && i_addr > 15'h5FFF; endsequence
  property p_mode; !o_dev_reset_n_ff; endproperty
  a_mode: assert property (p_mode) else $error("reset pin up");
  property p_pulse; !wp |-> hv && rs; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse pins");
  property p_width; $rose(wp) |-> low_ff == 11'h3E8; endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_latch; sel && !rs |-> wp && !o_dq_oe_n_ff; endproperty
  a_latch: assert property (p_latch) else $error("latch pins");
  property p_clash; !sel && !rs |-> o_dq_oe_n_ff; endproperty
  a_clash: assert property (p_clash) else $error("bus clash");
  property p_idle; o_ready |-> sel && rs && wp; endproperty
  a_idle: assert property (p_idle) else $error("idle pins");
  property p_bad; s_taken ##0 s_bad |=> o_done_ff && o_fail_ff; endproperty
  a_bad: assert property (p_bad) else $error("bad address");
  property p_read; s_taken ##0 i_cmd == 3'h0 |=> !hv [*8]; endproperty
  a_read: assert property (p_read) else $error("read volts");
endmodule // ppp_ctrl_assertions
bind ppp_ctrl ppp_ctrl_assertions ppp_ctrl_assertions_inst (.i_core_clk,
  .i_reset, .i_start, .o_ready, .o_done_ff, .o_fail_ff, .o_dq_oe_n_ff,
  .o_prom_select_n_ff, .o_read_strobe_n_ff, .o_write_pulse_n_ff,
  .o_dev_reset_n_ff, .o_high_volt_ff, .i_cmd, .i_addr);

/* test/ppp_prom_model.sv */
// Pin-level model of the PROM array in programming mode.
// Pins are sampled on the falling clock edge, when they have settled.
`timescale 1ns/100ps
module ppp_prom_model (
  input  wire        i_core_clk, i_stuck, i_oe_n, i_sel_n, i_rs_n,
  input  wire        i_wp_n, i_rst_n, i_hv,
  input  wire [14:0] i_addr,
  input  wire [7:0]  i_dq,
  output wire [7:0]  o_bus
);
  reg  [7:0]  mem [0:24575];
  reg  [22:0] lat [0:3];
  reg  [7:0]  last_ff = 8'h00;
  integer     k;
  wire        on = !i_rst_n;
  wire        drv = on && !i_sel_n && !i_rs_n;
  wire        write_pulse_n = on && i_hv && !i_wp_n && i_rs_n && !i_stuck;
  // Released bus flips each cycle between the inverse of the stale byte and the stale byte
  assign o_bus = drv ? mem[i_addr] : (!i_oe_n ? i_dq : ~last_ff);
  initial for (k = 0; k < 24576; k = k + 1) mem[k] = 8'hFF;
  always @(negedge i_core_clk) begin
    last_ff <= o_bus;
    if (on && i_sel_n && i_wp_n && !i_rs_n)
      lat[i_addr[1:0]] <= {i_addr, o_bus};
    if (write_pulse_n && i_sel_n)
      for (k = 0; k < 4; k = k + 1) mem[lat[k][22:8]] <= lat[k][7:0];
    if (write_pulse_n && !i_sel_n) mem[i_addr] <= o_bus;
  end
endmodule // ppp_prom_model

/* test/tb.sv */
// Self-checking bench for the PROM programming controller.
// Uses the pin-level PROM model; checker is bound to the top.
`timescale 1ns/100ps
module tb;
  reg         i_core_clk = 1'b0, i_reset = 1'b1, i_start = 1'b0, stuck = 1'b0;
  reg  [2:0]  i_cmd = 3'h0;
  reg  [14:0] i_addr = 15'h0000;
  reg  [7:0]  i_wdata = 8'h00;
  reg  [31:0] i_page_data = 32'h5A3C0F96;
  wire [7:0]  i_dq_in, o_rdata_ff, o_dq_out_ff;
  wire [14:0] o_prom_addr_ff;
  wire        o_ready, o_done_ff, o_fail_ff, o_dq_oe_n_ff, o_dev_reset_n_ff;
  wire        o_prom_select_n_ff, o_read_strobe_n_ff, o_write_pulse_n_ff;
  wire        o_high_volt_ff;
  integer     miscompares = 0, tests_run = 0, cycles = 0, pulses = 0, k;
  always #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) cycles = cycles + 1;
  always @(negedge o_write_pulse_n_ff) pulses = pulses + 1;
  ppp_ctrl ppp_ctrl_inst (.i_core_clk, .i_reset, .i_start, .i_cmd, .i_addr,
    .i_wdata, .i_page_data, .i_dq_in, .o_ready, .o_done_ff, .o_fail_ff,
    .o_rdata_ff, .o_prom_addr_ff, .o_dq_out_ff, .o_dq_oe_n_ff,
    .o_prom_select_n_ff, .o_read_strobe_n_ff, .o_write_pulse_n_ff,
    .o_dev_reset_n_ff, .o_high_volt_ff);
  ppp_prom_model ppp_prom_model_inst (.i_core_clk, .i_stuck(stuck),
    .i_oe_n(o_dq_oe_n_ff), .i_sel_n(o_prom_select_n_ff),
    .i_rs_n(o_read_strobe_n_ff), .i_wp_n(o_write_pulse_n_ff),
    .i_rst_n(o_dev_reset_n_ff), .i_hv(o_high_volt_ff),
    .i_addr(o_prom_addr_ff), .i_dq(o_dq_out_ff), .o_bus(i_dq_in));
  task chk(input [7:0] got, input [7:0] exp); begin
    tests_run = tests_run + 1;
    if (got !== exp) miscompares = miscompares + 1;
    if (got !== exp) $display("[ERR] %0t got %h want %h", $time, got, exp);
  end endtask
  task tally_and_finish; begin
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end endtask
  // Cycle ceiling bounds the wait, so a lost done cannot hang the run
  task run(input [2:0] c, input [14:0] a, input [7:0] d, input f); begin
    @(negedge i_core_clk);
    {i_cmd, i_addr, i_wdata, i_start} = {c, a, d, 1'b1};
    @(negedge i_core_clk);
    i_start = 1'b0;
    while (o_done_ff !== 1'b1 && cycles < 30000) @(negedge i_core_clk);
    chk({6'h00, o_done_ff, o_fail_ff}, {6'h00, 1'b1, f});
    if (cycles >= 30000) tally_and_finish;
  end endtask
  task t_read; begin
    run(3'h0, 15'h1234, 8'h00, 1'b0);
    chk(o_rdata_ff, 8'hFF);
    run(3'h3, 15'h5FFF, 8'h00, 1'b0);
  end endtask
  task t_byte; begin
    pulses = 0;
    run(3'h1, 15'h6000, 8'hA5, 1'b1);
    run(3'h1, 15'h5FFF, 8'hA5, 1'b0);
    chk(8'(pulses), 8'h01);
    run(3'h0, 15'h5FFF, 8'h00, 1'b0);
    chk(o_rdata_ff, 8'hA5);
  end endtask
  task t_page; begin
    run(3'h2, 15'h0012, 8'h00, 1'b0);
    for (k = 0; k < 4; k = k + 1) begin
      run(3'h0, 15'h0010 + 15'(k), 8'h00, 1'b0);
      chk(o_rdata_ff, 8'(i_page_data >> (8 * k)));
    end
  end endtask
  task t_retry; begin
    stuck = 1'b1;
    pulses = 0;
    run(3'h1, 15'h0200, 8'h0F, 1'b1);
    chk(8'(pulses), 8'h0A);
    stuck = 1'b0;
  end endtask
  initial begin
    repeat (2) @(negedge i_core_clk);
    i_reset = 1'b0;
    t_read;
    t_byte;
    t_page;
    t_retry;
    tally_and_finish;
  end
endmodule // tb
